//--- design/timer16_defs.svh
// constants for the 16-bit timer: register indices, field positions, reset values
`ifndef TIMER16_DEFS_SVH
`define TIMER16_DEFS_SVH

// ------------------------------------------------------------
// register indices, byte address is four times the index
// ------------------------------------------------------------
`define IDX_CTL_TWO   6'h11
`define IDX_CTL_ONE   6'h12
`define IDX_FLAGS     6'h13
`define IDX_CAP1_HI   6'h14
`define IDX_CAP1_LO   6'h15
`define IDX_CMP1_HI   6'h16
`define IDX_CMP1_LO   6'h17
`define IDX_CNT_HI    6'h18
`define IDX_CNT_LO    6'h19
`define IDX_ACNT_HI   6'h1A
`define IDX_ACNT_LO   6'h1B
`define IDX_CAP2_HI   6'h1C
`define IDX_CAP2_LO   6'h1D
// compare two bytes sit just above the last capture byte
`define IDX_CMP2_HI_ALIAS 6'h1E
`define IDX_CMP2_LO_ALIAS 6'h1F

// ------------------------------------------------------------
// control one fields
// ------------------------------------------------------------
`define C1_CAP_IE     7
`define C1_CMP_IE     6
`define C1_OVF_IE     5
`define C1_FORCE_TWO  4
`define C1_FORCE_ONE  3
`define C1_LEVEL_TWO  2
`define C1_CAP_EDGE1  1
`define C1_LEVEL_ONE  0

// ------------------------------------------------------------
// control two fields
// ------------------------------------------------------------
`define C2_PIN_EN1    7
`define C2_PIN_EN2    6
`define C2_ONE_PULSE  5
`define C2_PWM        4
`define C2_CLK_HI     3
`define C2_CLK_LO     2
`define C2_CAP_EDGE2  1
`define C2_EXT_EDGE   0

// ------------------------------------------------------------
// flag fields
// ------------------------------------------------------------
`define FL_CAP_ONE    7
`define FL_CMP_ONE    6
`define FL_OVF        5
`define FL_CAP_TWO    4
`define FL_CMP_TWO    3
`define FL_MASK       8'hF8

// ------------------------------------------------------------
// reset and load values, clock select codes
// ------------------------------------------------------------
`define CTL_RST       8'h00
`define CNT_RST       16'hFFFC
`define CAP_LOAD_OPM  16'hFFFD
`define CNT_TOP       16'hFFFF
`define CMP_RST       16'h8000
`define CLK_DIV4      2'h0
`define CLK_DIV2      2'h1
`define CLK_DIV8      2'h2
`define CLK_EXT       2'h3

`endif

//--- design/timer16_pkg.sv
// types shared by the 16-bit timer modules
package timer16_pkg;

    typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_t;

    typedef struct packed {
        logic [7:0]  ctl_one;
        logic [7:0]  ctl_two;
        logic [7:0]  flags;
        logic [7:0]  armed;
        logic [15:0] cnt;
        logic [15:0] cmp_one;
        logic [15:0] cmp_two;
        logic [15:0] cap_one;
        logic [15:0] cap_two;
        logic        cmp_one_hold;
        logic        cmp_two_hold;
        logic [2:0]  presc;
        logic        pin_one;
        logic        pin_two;
        logic        halt_prev;
        logic        cap_arm_one;
        logic        cap_arm_two;
        bus_state_t  bus;
        logic [7:0]  rdata;
    } timer_state_t;

    typedef struct packed {
        logic prev;
        logic valid;
    } edge_state_t;

endpackage

//--- design/edge_pick.sv
// selectable rising or falling edge detector for a synchronous pin
`timescale 1ns/10ps
module edge_pick (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic pin_i,
    input  wire logic rise_sel_i,
    output logic      edge_o
);
    import timer16_pkg::*;

    edge_state_t st_r;
    edge_state_t st_nxt;

    // ------------------------------------------------------------
    // state update
    // ------------------------------------------------------------
    // valid blocks a false edge in the first cycle after reset
    always_comb begin
        st_nxt       = st_r;
        st_nxt.prev  = pin_i;
        st_nxt.valid = 1'b1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // one-cycle pulse on the chosen transition
    assign edge_o = st_r.valid & (rise_sel_i ? (pin_i & ~st_r.prev) : (~pin_i & st_r.prev));

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    edge_rise_pick_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (edge_o && rise_sel_i) |-> (pin_i && !st_r.prev))
        else $error("rising select fired on a non-rising pin");
    edge_fall_pick_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_r.valid && !rise_sel_i && !pin_i && $past(pin_i)) |-> edge_o)
        else $error("falling edge missed");
endmodule

//--- design/timer16_core.sv
// 16-bit timer with capture, compare, one-pulse, PWM and low-power behaviour
//
// Implementation choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
`include "timer16_defs.svh"
module timer16_core #(
    parameter bit HAS_EXT_CLOCK = 1'b1
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [31:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    input  wire logic        wait_i,
    input  wire logic        halt_i,
    input  wire logic        global_mask_i,
    input  wire logic        capture_pin_one_i,
    input  wire logic        capture_pin_two_i,
    input  wire logic        ext_clock_pin_i,
    output logic             compare_pin_one_o,
    output logic             compare_pin_one_oe_n_o,
    output logic             compare_pin_two_o,
    output logic             compare_pin_two_oe_n_o,
    output logic             irq_o,
    output logic             wake_o
);
    import timer16_pkg::*;

    timer16_pkg::timer_state_t st_r;
    timer16_pkg::timer_state_t st_nxt;

    logic [5:0]  idx;
    logic        mapped;
    logic        take;
    logic        wr;
    logic        cap_edge_one;
    logic        cap_edge_two;
    logic        ext_edge;
    logic        tick;
    logic        pwm_on;
    logic        opm_on;
    logic        pending;
    logic [7:0]  enabled;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // readback of one byte register
    function automatic logic [7:0] reg_read(input logic [5:0] i, input timer_state_t s);
        logic [7:0] v;
        v = 8'h00;
        case (i)
            `IDX_CTL_TWO: v = s.ctl_two;
            `IDX_CTL_ONE: v = s.ctl_one;
            `IDX_FLAGS:   v = s.flags & `FL_MASK;
            `IDX_CAP1_HI: v = s.cap_one[15:8];
            `IDX_CAP1_LO: v = s.cap_one[7:0];
            `IDX_CMP1_HI: v = s.cmp_one[15:8];
            `IDX_CMP1_LO: v = s.cmp_one[7:0];
            `IDX_CMP2_HI_ALIAS: v = s.cmp_two[15:8];
            `IDX_CMP2_LO_ALIAS: v = s.cmp_two[7:0];
            `IDX_CNT_HI:  v = s.cnt[15:8];
            `IDX_CNT_LO:  v = s.cnt[7:0];
            `IDX_ACNT_HI: v = s.cnt[15:8];
            `IDX_ACNT_LO: v = s.cnt[7:0];
            `IDX_CAP2_HI: v = s.cap_two[15:8];
            `IDX_CAP2_LO: v = s.cap_two[7:0];
            default:      v = 8'h00;
        endcase
        return v;
    endfunction

    // prescaler tick: divide-by mask chosen by the clock select field
    function automatic logic div_tick(input logic [1:0] sel, input logic [2:0] p);
        logic t;
        t = 1'b0;
        case (sel)
            `CLK_DIV2: t = (p[0] == 1'b1);
            `CLK_DIV4: t = (p[1:0] == 2'h3);
            `CLK_DIV8: t = (p == 3'h7);
            default:   t = 1'b0;
        endcase
        return t;
    endfunction

    // ------------------------------------------------------------
    // edge detection on capture and external clock pins
    // ------------------------------------------------------------
    edge_pick u_cap_one (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .pin_i      (capture_pin_one_i),
        .rise_sel_i (st_r.ctl_one[`C1_CAP_EDGE1]),
        .edge_o     (cap_edge_one)
    );

    edge_pick u_cap_two (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .pin_i      (capture_pin_two_i),
        .rise_sel_i (st_r.ctl_two[`C2_CAP_EDGE2]),
        .edge_o     (cap_edge_two)
    );

    edge_pick u_ext_clk (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .pin_i      (ext_clock_pin_i),
        .rise_sel_i (st_r.ctl_two[`C2_EXT_EDGE]),
        .edge_o     (ext_edge)
    );

    // ------------------------------------------------------------
    // decode and mode terms
    // ------------------------------------------------------------
    // pwm wins over one-pulse when both are set
    assign idx    = adr_i[7:2];
    assign mapped = (adr_i[31:8] == 24'h000000) && (idx >= `IDX_CTL_TWO)
                    && (idx <= `IDX_CMP2_LO_ALIAS);
    assign take   = cyc_i & stb_i & (st_r.bus == BUS_IDLE);
    assign wr     = take & we_i & sel_i[0] & mapped;
    assign pwm_on = st_r.ctl_two[`C2_PWM];
    assign opm_on = st_r.ctl_two[`C2_ONE_PULSE] & ~pwm_on;

    // counter clock; wait_i is deliberately not looked at
    always_comb begin
        if (halt_i) begin
            tick = 1'b0;
        end else if (st_r.ctl_two[`C2_CLK_HI:`C2_CLK_LO] == `CLK_EXT) begin
            tick = HAS_EXT_CLOCK ? ext_edge : 1'b0;
        end else begin
            tick = div_tick(st_r.ctl_two[`C2_CLK_HI:`C2_CLK_LO], st_r.presc);
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // clears are applied first so that a same-cycle hardware set wins
    always_comb begin
        logic [15:0] c;
        c         = st_r.cnt + 16'h0001;
        st_nxt    = st_r;
        st_nxt.halt_prev = halt_i;
        st_nxt.bus = take ? BUS_ACK : BUS_IDLE;
        if (!halt_i) begin
            st_nxt.presc = st_r.presc + 3'h1;
        end
        if (take) begin
            st_nxt.rdata = mapped ? reg_read(idx, st_r) : 8'h00;
        end
        // flag clearing by the two-step access
        if (take && mapped && !we_i && idx == `IDX_FLAGS) begin
            st_nxt.armed = st_r.flags & `FL_MASK;
        end
        if (take && mapped && idx == `IDX_CAP1_LO && st_r.armed[`FL_CAP_ONE]) begin
            st_nxt.flags[`FL_CAP_ONE] = 1'b0;
            st_nxt.armed[`FL_CAP_ONE] = 1'b0;
        end
        if (take && mapped && idx == `IDX_CMP1_LO && st_r.armed[`FL_CMP_ONE]) begin
            st_nxt.flags[`FL_CMP_ONE] = 1'b0;
            st_nxt.armed[`FL_CMP_ONE] = 1'b0;
        end
        if (take && mapped && idx == `IDX_CNT_LO && st_r.armed[`FL_OVF]) begin
            st_nxt.flags[`FL_OVF] = 1'b0;
            st_nxt.armed[`FL_OVF] = 1'b0;
        end
        if (take && mapped && idx == `IDX_CAP2_LO && st_r.armed[`FL_CAP_TWO]) begin
            st_nxt.flags[`FL_CAP_TWO] = 1'b0;
            st_nxt.armed[`FL_CAP_TWO] = 1'b0;
        end
        if (take && mapped && idx == `IDX_CMP2_LO_ALIAS && st_r.armed[`FL_CMP_TWO]) begin
            st_nxt.flags[`FL_CMP_TWO] = 1'b0;
            st_nxt.armed[`FL_CMP_TWO] = 1'b0;
        end
        // register writes; compare is held off between high and low byte writes
        if (wr) begin
            case (idx)
                `IDX_CTL_TWO: st_nxt.ctl_two = dat_i[7:0];
                `IDX_CTL_ONE: st_nxt.ctl_one = dat_i[7:0];
                `IDX_CMP1_HI: begin
                    st_nxt.cmp_one[15:8] = dat_i[7:0];
                    st_nxt.cmp_one_hold  = 1'b1;
                end
                `IDX_CMP1_LO: begin
                    st_nxt.cmp_one[7:0] = dat_i[7:0];
                    st_nxt.cmp_one_hold = 1'b0;
                end
                `IDX_CMP2_HI_ALIAS: begin
                    st_nxt.cmp_two[15:8] = dat_i[7:0];
                    st_nxt.cmp_two_hold  = 1'b1;
                end
                `IDX_CMP2_LO_ALIAS: begin
                    st_nxt.cmp_two[7:0] = dat_i[7:0];
                    st_nxt.cmp_two_hold = 1'b0;
                end
                `IDX_CNT_LO, `IDX_ACNT_LO: begin
                    if (!halt_i) begin
                        st_nxt.cnt = `CNT_RST;
                    end
                end
                default: st_nxt.ctl_one = st_nxt.ctl_one;
            endcase
        end
        // counting and compare events, evaluated on the value being entered
        if (tick) begin
            st_nxt.cnt = c;
            if (st_r.cnt == `CNT_TOP) begin
                st_nxt.flags[`FL_OVF] = 1'b1;
            end
            if (c == st_r.cmp_one && !st_r.cmp_one_hold) begin
                st_nxt.pin_one = st_r.ctl_one[`C1_LEVEL_ONE];
                if (!pwm_on && !opm_on) begin
                    st_nxt.flags[`FL_CMP_ONE] = 1'b1;
                end
            end
            if (c == st_r.cmp_two && !st_r.cmp_two_hold) begin
                if (pwm_on) begin
                    st_nxt.cnt = `CNT_RST;
                    st_nxt.pin_one = st_r.ctl_one[`C1_LEVEL_TWO];
                    st_nxt.flags[`FL_CAP_ONE] = 1'b1;
                end else begin
                    st_nxt.flags[`FL_CMP_TWO] = 1'b1;
                    if (!opm_on) begin
                        st_nxt.pin_two = st_r.ctl_one[`C1_LEVEL_TWO];
                    end
                end
            end
        end
        // captures; in halt the edge only arms the capture logic
        if (halt_i) begin
            st_nxt.cap_arm_one = st_r.cap_arm_one | (cap_edge_one & ~pwm_on & ~opm_on);
            st_nxt.cap_arm_two = st_r.cap_arm_two | cap_edge_two;
        end else begin
            if (cap_edge_one && opm_on) begin
                st_nxt.cnt = `CNT_RST;
                st_nxt.pin_one = st_r.ctl_one[`C1_LEVEL_TWO];
                st_nxt.flags[`FL_CAP_ONE] = 1'b1;
                st_nxt.cap_one = `CAP_LOAD_OPM;
            end else if (cap_edge_one && !pwm_on) begin
                st_nxt.flags[`FL_CAP_ONE] = 1'b1;
                st_nxt.cap_one = st_r.cnt;
            end
            if (cap_edge_two) begin
                st_nxt.flags[`FL_CAP_TWO] = 1'b1;
                st_nxt.cap_two = st_r.cnt;
            end
            // wake-up from halt by interrupt completes an armed capture
            if (st_r.halt_prev) begin
                st_nxt.cap_arm_one = 1'b0;
                st_nxt.cap_arm_two = 1'b0;
                if (st_r.cap_arm_one) begin
                    st_nxt.flags[`FL_CAP_ONE] = 1'b1;
                    st_nxt.cap_one = st_r.cnt;
                end
                if (st_r.cap_arm_two) begin
                    st_nxt.flags[`FL_CAP_TWO] = 1'b1;
                    st_nxt.cap_two = st_r.cnt;
                end
            end
        end
        // forced levels; no effect in the pulse modes
        if (!pwm_on && !opm_on) begin
            if (st_r.ctl_one[`C1_FORCE_ONE]) begin
                st_nxt.pin_one = st_r.ctl_one[`C1_LEVEL_ONE];
            end
            if (st_r.ctl_one[`C1_FORCE_TWO]) begin
                st_nxt.pin_two = st_r.ctl_one[`C1_LEVEL_TWO];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r         <= '0;
            st_r.ctl_one <= `CTL_RST;
            st_r.ctl_two <= `CTL_RST;
            st_r.cnt     <= `CNT_RST;
            st_r.cmp_one <= `CMP_RST;
            st_r.cmp_two <= `CMP_RST;
            st_r.bus     <= BUS_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // pin enables only route the level; compare logic runs regardless
    assign compare_pin_one_o      = st_r.pin_one;
    assign compare_pin_two_o      = st_r.pin_two;
    assign compare_pin_one_oe_n_o = ~st_r.ctl_two[`C2_PIN_EN1];
    assign compare_pin_two_oe_n_o = ~st_r.ctl_two[`C2_PIN_EN2];
    assign dat_o                  = {24'h000000, st_r.rdata};
    assign ack_o                  = (st_r.bus == BUS_ACK);

    // shared request line; wake only from wait, halt has no timer wake-up
    assign enabled = {st_r.ctl_one[`C1_CAP_IE], st_r.ctl_one[`C1_CMP_IE],
                      st_r.ctl_one[`C1_OVF_IE], st_r.ctl_one[`C1_CAP_IE],
                      st_r.ctl_one[`C1_CMP_IE], 3'h0};
    assign pending = |(st_r.flags & enabled);
    assign irq_o   = pending & ~global_mask_i;
    assign wake_o  = pending & wait_i & ~halt_i;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence bus_req_s;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence bus_ack_s;
        ack_o ##1 !ack_o;
    endsequence
    property bus_one_ack_p;
        bus_req_s |=> bus_ack_s;
    endproperty

    bus_single_ack_a: assert property (bus_one_ack_p)
        else $error("ack not given for exactly one cycle");
    irq_cap_gate_a: assert property (($rose(st_r.flags[`FL_CAP_TWO]) && st_r.ctl_one[`C1_CAP_IE]
        && !global_mask_i) |-> irq_o)
        else $error("capture flag with enable did not raise the request");
    irq_cmp_gate_a: assert property ((irq_o && !st_r.ctl_one[`C1_CAP_IE]
        && !st_r.ctl_one[`C1_OVF_IE]) |-> st_r.ctl_one[`C1_CMP_IE])
        else $error("request without any matching enable");
    irq_ovf_gate_a: assert property ((st_r.cnt == `CNT_TOP && tick) |=>
        (st_r.flags[`FL_OVF] && (irq_o || !st_r.ctl_one[`C1_OVF_IE] || global_mask_i)))
        else $error("overflow flag or its request wrong after rollover");
    irq_mask_gate_a: assert property (global_mask_i |-> !irq_o)
        else $error("request raised while globally masked");
    pwm_no_cmp_a: assert property ((pwm_on && $past(pwm_on)) |->
        !$rose(st_r.flags[`FL_CMP_ONE]) && !$rose(st_r.flags[`FL_CMP_TWO]))
        else $error("compare flag set in pwm mode");
    force_pin_one_a: assert property ((st_r.ctl_one[`C1_FORCE_ONE] && !pwm_on && !opm_on)
        ##1 (st_r.ctl_one[`C1_FORCE_ONE] && !pwm_on && !opm_on)
        |-> compare_pin_one_o == $past(st_r.ctl_one[`C1_LEVEL_ONE]))
        else $error("forced level not on compare pin one");
    halt_freeze_a: assert property ((halt_i && $past(halt_i)) |-> $stable(st_r.cnt))
        else $error("counter moved during halt");
    halt_no_wake_a: assert property (halt_i |-> !wake_o)
        else $error("timer woke the cpu from halt");
    halt_capture_a: assert property ((halt_i && cap_edge_two) ##1 halt_i [*1] ##1 !halt_i
        |=> st_r.flags[`FL_CAP_TWO])
        else $error("armed capture not completed after halt exit");
endmodule

//--- sim/pin_partner.sv
// pin-side model: capture pins and external clock pin of the timer
`timescale 1ns/10ps
module pin_partner (
    input  wire logic clk_i,
    output logic      cap_one_o,
    output logic      cap_two_o,
    output logic      ext_clk_o
);
    // pins idle low, so a falling-edge select sees no spurious event
    initial begin
        cap_one_o = 1'b0;
        cap_two_o = 1'b0;
        ext_clk_o = 1'b0;
    end

    // the high half of each external clock pulse spans three cycles and the low half four, slow enough to sample
    task automatic ext_pulses(input int n);
        repeat (n) begin
            @(posedge clk_i);
            ext_clk_o <= 1'b1;
            repeat (3) @(posedge clk_i);
            ext_clk_o <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
    endtask

    // one pulse on capture pin two: rise, fall two cycles later
    task automatic cap_two_pulse();
        @(posedge clk_i);
        cap_two_o <= 1'b1;
        repeat (2) @(posedge clk_i);
        cap_two_o <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    // one falling edge on capture pin one, then held low
    task automatic cap_one_fall();
        @(posedge clk_i);
        cap_one_o <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask

    // one rising edge on capture pin one, then held high
    task automatic cap_one_rise();
        @(posedge clk_i);
        cap_one_o <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask
endmodule

//--- sim/tb_timer16_core.sv
// self-checking bench for the 16-bit timer core
`timescale 1ns/10ps
`include "timer16_defs.svh"
module tb_timer16_core;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [31:0] adr = 32'h0, wdat = 32'h0, dat_o;
    logic        ack_o, wait_i = 1'b0, halt_i = 1'b0, mask_i = 1'b0;
    logic        cap_one, cap_two, ext_clk, pin_one, oe_one_n, pin_two, oe_two_n, irq_o, wake_o;
    logic [7:0]  rd;
    int          bad_count = 0, checks_done = 0, cycles = 0;

    timer16_core timer16_core_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
        .wait_i(wait_i), .halt_i(halt_i), .global_mask_i(mask_i),
        .capture_pin_one_i(cap_one), .capture_pin_two_i(cap_two), .ext_clock_pin_i(ext_clk),
        .compare_pin_one_o(pin_one), .compare_pin_one_oe_n_o(oe_one_n),
        .compare_pin_two_o(pin_two), .compare_pin_two_oe_n_o(oe_two_n),
        .irq_o(irq_o), .wake_o(wake_o));
    pin_partner pin_partner_i (.clk_i(clk_i), .cap_one_o(cap_one), .cap_two_o(cap_two),
        .ext_clk_o(ext_clk));

    // 100 MHz clock
    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // hang guard: whole run needs well under this many cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // classic wishbone cycle; ack is sampled at the edge, before the slave's own update
    task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {24'h000000, idx, 2'b00};
        wdat <= {24'h000000, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic settle();
        repeat (2) @(posedge clk_i);
    endtask

    task automatic t_regs();
        bus(0, `IDX_CTL_ONE, 8'h00); check(rd, 8'h00);
        bus(0, `IDX_CTL_TWO, 8'h00); check(rd, 8'h00);
        bus(0, `IDX_CMP1_HI, 8'h00); check(rd, 8'h80);
        bus(0, 6'h05, 8'h00); check(rd, 8'h00);
        bus(1, `IDX_CTL_ONE, 8'hA5); bus(0, `IDX_CTL_ONE, 8'h00); check(rd, 8'hA5);
        bus(1, `IDX_CTL_ONE, 8'h00);
        $display("test regs done");
    endtask

    task automatic t_force();
        bus(1, `IDX_CTL_TWO, 8'hC0);
        bus(1, `IDX_CTL_ONE, 8'h09); settle();
        check({oe_one_n, pin_one}, 2'b01);
        bus(1, `IDX_CTL_ONE, 8'h14); settle();
        check({oe_two_n, pin_two}, 2'b01);
        bus(1, `IDX_CTL_TWO, 8'h00); settle();
        check({oe_two_n, oe_one_n}, 2'b11);
        $display("test force done");
    endtask

    // overflow is already pending from the free run, so masks matter here
    task automatic t_capture();
        bus(1, `IDX_CTL_ONE, 8'h82); settle();
        check(irq_o, 1'b0);
        pin_partner_i.cap_one_rise();
        bus(0, `IDX_FLAGS, 8'h00); check(rd & 8'h80, 8'h80);
        check(irq_o, 1'b1);
        mask_i <= 1'b1; settle();
        check(irq_o, 1'b0);
        mask_i <= 1'b0;
        bus(0, `IDX_CAP1_LO, 8'h00);
        bus(0, `IDX_FLAGS, 8'h00); check(rd & 8'h80, 8'h00);
        $display("test capture done");
    endtask

    task automatic t_ext();
        bus(1, `IDX_CTL_TWO, 8'h0D);
        bus(0, `IDX_FLAGS, 8'h00);
        bus(1, `IDX_CNT_LO, 8'h00);
        bus(0, `IDX_FLAGS, 8'h00); check(rd & 8'h20, 8'h00);
        pin_partner_i.ext_pulses(3);
        bus(0, `IDX_CNT_LO, 8'h00); check(rd, 8'hFF);
        pin_partner_i.ext_pulses(1);
        bus(0, `IDX_FLAGS, 8'h00); check(rd & 8'h20, 8'h20);
        bus(1, `IDX_CTL_ONE, 8'h20); settle();
        check(irq_o, 1'b1);
        $display("test ext clock done");
    endtask

    // wait is raised in halt too, so only the halt gating keeps wake low
    task automatic t_lowpower();
        bus(1, `IDX_CTL_ONE, 8'hA0);
        pin_partner_i.ext_pulses(1);
        halt_i <= 1'b1;
        wait_i <= 1'b1; settle();
        check(wake_o, 1'b0);
        pin_partner_i.ext_pulses(2);
        pin_partner_i.cap_two_pulse();
        halt_i <= 1'b0; settle();
        check(wake_o, 1'b1);
        bus(0, `IDX_FLAGS, 8'h00); check(rd & 8'h10, 8'h10);
        bus(0, `IDX_CAP2_LO, 8'h00); check(rd, 8'h01);
        pin_partner_i.ext_pulses(1);
        bus(0, `IDX_CNT_LO, 8'h00); check(rd, 8'h02);
        wait_i <= 1'b0;
        $display("test low power done");
    endtask

    // a 16-cycle span between counter reads holds an exact tick count
    task automatic t_div(input logic [1:0] code, input logic [7:0] ticks);
        logic [7:0] first;
        bus(1, `IDX_CTL_TWO, {4'h0, code, 2'b00});
        bus(0, `IDX_CNT_LO, 8'h00);
        first = rd;
        repeat (13) @(posedge clk_i);
        bus(0, `IDX_CNT_LO, 8'h00);
        check(8'(rd - first), ticks);
        $display("test divider done");
    endtask

    // pwm: FFFD drops the pin, FFFE ends the period; then one-pulse
    task automatic t_pulse_modes();
        bus(1, `IDX_CMP1_HI, 8'hFF);
        bus(1, `IDX_CMP1_LO, 8'hFD);
        bus(1, `IDX_CMP2_HI_ALIAS, 8'hFF);
        bus(1, `IDX_CMP2_LO_ALIAS, 8'hFE);
        bus(1, `IDX_CNT_LO, 8'h00);
        bus(1, `IDX_CTL_ONE, 8'h84);
        bus(1, `IDX_CTL_TWO, 8'h9D);
        pin_partner_i.ext_pulses(1);
        check({oe_one_n, pin_one}, 2'b00);
        pin_partner_i.ext_pulses(1);
        check({irq_o, pin_one}, 2'b11);
        bus(0, `IDX_FLAGS, 8'h00); check(rd, 8'h80);
        bus(0, `IDX_CNT_LO, 8'h00); check(rd, 8'hFC);
        pin_partner_i.ext_pulses(1);
        bus(1, `IDX_CTL_TWO, 8'hAD);
        pin_partner_i.cap_one_fall();
        check(pin_one, 1'b1);
        bus(0, `IDX_CNT_LO, 8'h00); check(rd, 8'hFC);
        bus(0, `IDX_CAP1_LO, 8'h00); check(rd, 8'hFD);
        pin_partner_i.ext_pulses(1);
        check(pin_one, 1'b0);
        $display("test pulse modes done");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs();
        t_div(2'h1, 8'h08);
        t_div(2'h2, 8'h02);
        t_div(2'h0, 8'h04);
        t_force();
        t_capture();
        t_ext();
        t_lowpower();
        t_pulse_modes();
        end_of_test();
    end
endmodule
